// ===== core/ncp_defs.svh
// Constants of the numeric coprocessor host port
`ifndef NCP_DEFS_SVH
`define NCP_DEFS_SVH
`define NCP_CMD_CTRL 2'h0
`define NCP_CMD_DATA 2'h2
`define NCP_OP_LOAD 4'h1
`define NCP_OP_STORE 4'h2
`define NCP_OP_ENTER_PROTECTED_INSTRUCTION 4'h3
`define NCP_OP_CLEX 4'h4
`define NCP_OP_INIT 4'h5
`define NCP_FMT_I16 3'h0
`define NCP_FMT_I32 3'h1
`define NCP_FMT_I64 3'h2
`define NCP_FMT_BCD 3'h3
`define NCP_FMT_R32 3'h4
`define NCP_FMT_R64 3'h5
`define NCP_FMT_R80 3'h6
`define NCP_WORDS_1 3'h1
`define NCP_WORDS_2 3'h2
`define NCP_WORDS_4 3'h4
`define NCP_WORDS_5 3'h5
`define NCP_BIAS_R32 15'h007F
`define NCP_BIAS_R64 15'h03FF
`define NCP_BIAS_R80 15'h3FFF
`define NCP_EMAX_R32 11'h0FF
`define NCP_EMAX_R64 11'h7FF
`define NCP_EXP_MAX 15'h7FFF
`define NCP_BCD_DIGITS 18
`define NCP_DIV_LAST 2'h2
`define NCP_PINS_IDLE 24'h460000
`endif

// ===== core/ncp_pkg.sv
// Types of the numeric coprocessor host port
package ncp_pkg;
  typedef struct packed {
    logic fast;
    logic sel_low;
    logic sel_high;
    logic [1:0] cmd;
    logic rd_n;
    logic wr_n;
    logic ack;
    logic [15:0] data;
  } ncp_pins_type;
  typedef struct packed {
    logic [4:0] spare;
    logic pop;
    logic [2:0] idx;
    logic [2:0] fmt;
    logic [3:0] op;
  } ncp_opcode_type;
  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [63:0] man;
  } ncp_ext_type;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_CONV, ST_STORE, ST_DRAIN} ncp_state_type;
endpackage

// ===== core/ncp_port.sv
// Numeric coprocessor host port: pin sync, clock mode, operand channel, register stack
`timescale 1ns/1ps
`include "ncp_defs.svh"
// Function
// RQ1: After reset the coprocessor is in real address mode.
// RQ2: The enter-protected opcode switches to protected address mode.
// RQ3: Protected mode is left only by reset, never by an opcode.
// RQ4: Any detected error or exception raises the error output.
// RQ5: Clock mode low divides the input clock by three.
// RQ6: Clock mode high uses the input clock directly.
// RQ7: Host uses the three coprocessor ports with both selects asserted.
// RQ8: Command bits come from latched host address bits one and two.
// RQ9: Software does no other I/O to the reserved coprocessor ports.
// RQ10: Request, acknowledge, busy, error wire to same-named host inputs.
// RQ11: Other data bus drivers are off while the host reads us.
// RQ12: Address decode qualifies on memory-versus-I/O for acknowledge cycles.
// RQ13: With the 32-bit host acknowledge is tied high.
// RQ14: The 32-bit host starts on request and ends after all words.
// RQ15: The 32-bit host uses its high I/O window decoded from A31.
// RQ16: The 32-bit host uses 16-bit cycles to the coprocessor.
// RQ17: A local bus controller times the 32-bit host's cycles.
// RQ18: Operands travel least significant word first.
// RQ19: Software should place operands at even addresses.
// RQ20: Loads convert integer, real and decimal formats to extended; stores reverse. Decimal stores are refused with an error here.
// RQ21: Eight 80-bit registers, used as stack or explicitly indexed.
// RQ22: No transfer happens unless low select is low and high select high.
// RQ23: Busy stays asserted while a command executes.
// RQ24: Request drops on acknowledge or last transfer, whichever first. Here an acknowledge drops it only while the last word is pending.
// RQ25: Exponent biases are 127, 1023 and 16383.
// RQ26: Asynchronous host inputs are synchronised before use.
module ncp_port import ncp_pkg::*; #(
  parameter int BUF_DEPTH = 2,
  parameter int STACK_DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clock_mode_select_i,
  input wire logic select_active_low_i,
  input wire logic select_active_high_i,
  input wire logic command_bit_zero_i,
  input wire logic command_bit_one_i,
  input wire logic coproc_read_strobe_n_i,
  input wire logic coproc_write_strobe_n_i,
  input wire logic operand_acknowledge_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic busy_o,
  output logic error_o,
  output logic operand_request_o,
  output logic protected_mode_o
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int TW = $clog2(STACK_DEPTH);

  function automatic logic [2:0] words_of(input logic [2:0] fmt);
    case (fmt)
      `NCP_FMT_I16: return `NCP_WORDS_1;
      `NCP_FMT_I32, `NCP_FMT_R32: return `NCP_WORDS_2;
      `NCP_FMT_I64, `NCP_FMT_R64: return `NCP_WORDS_4;
      default: return `NCP_WORDS_5;
    endcase
  endfunction

  function automatic ncp_ext_type int_to_ext(input logic [63:0] v);
    ncp_ext_type r;
    logic [63:0] m;
    logic [5:0] p;
    r = '0;
    m = v[63] ? 64'(-v) : v;
    p = 6'h0;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) p = 6'(i);
    end
    r.sign = v[63];
    if (m != 64'h0) begin
      r.exp = `NCP_BIAS_R80 + 15'(p);
      r.man = m << (6'h3F - p);
    end
    return r;
  endfunction

  function automatic ncp_ext_type real_to_ext(input logic s, input logic [10:0] e,
      input logic [10:0] emax, input logic [14:0] bias, input logic [51:0] f);
    ncp_ext_type r;
    r = '0;
    r.sign = s;
    if (e != 11'h0) begin
      r.man = {1'b1, f, 11'h0};
      r.exp = (e == emax) ? `NCP_EXP_MAX : 15'(15'(e) - bias + `NCP_BIAS_R80); // RQ25
    end
    return r;
  endfunction

  function automatic ncp_ext_type load_conv(input logic [2:0] fmt, input logic [79:0] raw);
    ncp_ext_type r;
    logic [63:0] acc;
    acc = 64'h0;
    case (fmt) // RQ20
      `NCP_FMT_I16: r = int_to_ext({{48{raw[15]}}, raw[15:0]});
      `NCP_FMT_I32: r = int_to_ext({{32{raw[31]}}, raw[31:0]});
      `NCP_FMT_I64: r = int_to_ext(raw[63:0]);
      `NCP_FMT_BCD: begin
        for (int i = `NCP_BCD_DIGITS - 1; i >= 0; i--) begin
          acc = acc * 64'hA + 64'(raw[4 * i +: 4]);
        end
        r = int_to_ext(acc);
        r.sign = raw[79];
      end
      `NCP_FMT_R32: r = real_to_ext(raw[31], {3'h0, raw[30:23]}, `NCP_EMAX_R32, `NCP_BIAS_R32,
          {raw[22:0], 29'h0});
      `NCP_FMT_R64: r = real_to_ext(raw[63], raw[62:52], `NCP_EMAX_R64, `NCP_BIAS_R64, raw[51:0]);
      default: r = ncp_ext_type'(raw);
    endcase
    return r;
  endfunction

  // Returns range error and narrowed exponent
  function automatic logic [11:0] ext_exp(input ncp_ext_type x, input logic [14:0] bias,
      input logic [10:0] emax);
    logic [14:0] e;
    e = 15'(x.exp - `NCP_BIAS_R80 + bias); // RQ25
    if (x.exp == 15'h0) return 12'h0;
    if (x.exp == `NCP_EXP_MAX) return {1'b0, emax};
    return {(x.exp <= 15'(`NCP_BIAS_R80 - bias)) || (e >= 15'(emax)), e[10:0]};
  endfunction

  // Returns {range error, memory image}
  function automatic logic [80:0] store_conv(input logic [2:0] fmt, input ncp_ext_type x);
    logic err;
    logic [79:0] raw;
    logic [63:0] mag;
    logic [14:0] sh;
    logic [11:0] q;
    err = 1'b0;
    raw = 80'h0;
    mag = 64'h0;
    sh = 15'(x.exp - `NCP_BIAS_R80);
    q = 12'h0;
    if (x.exp >= `NCP_BIAS_R80 && sh <= 15'h3F) mag = x.man >> (6'h3F - sh[5:0]);
    if (x.exp < `NCP_BIAS_R80) sh = 15'h0;
    case (fmt) // RQ20
      `NCP_FMT_I16: begin
        err = sh > 15'hE;
        raw[15:0] = x.sign ? 16'(-mag[15:0]) : mag[15:0];
      end
      `NCP_FMT_I32: begin
        err = sh > 15'h1E;
        raw[31:0] = x.sign ? 32'(-mag[31:0]) : mag[31:0];
      end
      `NCP_FMT_I64: begin
        err = sh > 15'h3E;
        raw[63:0] = x.sign ? 64'(-mag) : mag;
      end
      `NCP_FMT_R32: begin
        q = ext_exp(x, `NCP_BIAS_R32, `NCP_EMAX_R32);
        err = q[11];
        raw[31:0] = {x.sign, q[7:0], x.man[62:40]};
      end
      `NCP_FMT_R64: begin
        q = ext_exp(x, `NCP_BIAS_R64, `NCP_EMAX_R64);
        err = q[11];
        raw[63:0] = {x.sign, q[10:0], x.man[62:11]};
      end
      `NCP_FMT_R80: raw = x;
      default: err = 1'b1;
    endcase
    return {err, raw};
  endfunction

  logic rst_meta_reg, rst_ok_reg;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_ok_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_ok_reg <= rst_meta_reg;
    end
  end

  // Three-stage pin sync; a bit moves once stages two and three agree
  ncp_pins_type pin_w, s1_reg, s2_reg, s3_reg, flt_reg, prev_reg;
  assign pin_w = '{clock_mode_select_i, select_active_low_i, select_active_high_i,
      {command_bit_one_i, command_bit_zero_i}, coproc_read_strobe_n_i, coproc_write_strobe_n_i,
      operand_acknowledge_i, data_i}; // RQ8
  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      s1_reg <= ncp_pins_type'(`NCP_PINS_IDLE);
      s2_reg <= ncp_pins_type'(`NCP_PINS_IDLE);
      s3_reg <= ncp_pins_type'(`NCP_PINS_IDLE);
      flt_reg <= ncp_pins_type'(`NCP_PINS_IDLE);
      prev_reg <= ncp_pins_type'(`NCP_PINS_IDLE);
    end else begin
      s1_reg <= pin_w; // RQ26
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (flt_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
      prev_reg <= flt_reg;
    end
  end

  // Internal clock enable
  logic [1:0] div_reg;
  logic ce_reg;
  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      div_reg <= 2'h0;
      ce_reg <= 1'b0;
    end else if (flt_reg.fast || div_reg == `NCP_DIV_LAST) begin
      div_reg <= 2'h0; // RQ6
      ce_reg <= 1'b1; // RQ5
    end else begin
      div_reg <= div_reg + 2'h1;
      ce_reg <= 1'b0;
    end
  end

  ncp_state_type st_reg;
  ncp_opcode_type opc_reg, opc_w;
  logic [2:0] xcnt_reg, pcnt_reg, nw;
  logic [79:0] outbuf_reg, opbuf_reg;
  logic [79:0] stack_reg [STACK_DEPTH];
  logic [STACK_DEPTH-1:0] valid_reg;
  logic [TW-1:0] top_reg, push_idx, sidx;
  logic [80:0] st_res;
  logic [15:0] fmem_reg [BUF_DEPTH];
  logic [PW-1:0] wp_reg, rp_reg;
  logic [PW:0] fcnt_reg;
  logic sel_ok, wr_evt, rd_end, ack_rise, ctl_wr, dat_wr, dat_rd, op_go, xfer, last_x;
  logic ld_fault, st_fault, bad_op, err_set, err_clr, push_en, in_ready, popping;

  assign sel_ok = !flt_reg.sel_low && flt_reg.sel_high; // RQ22 RQ7
  assign wr_evt = sel_ok && prev_reg.wr_n && !flt_reg.wr_n;
  assign rd_end = data_oe_o && !prev_reg.rd_n && flt_reg.rd_n;
  assign ack_rise = flt_reg.ack && !prev_reg.ack; // RQ13
  assign ctl_wr = wr_evt && flt_reg.cmd == `NCP_CMD_CTRL;
  assign dat_wr = wr_evt && flt_reg.cmd == `NCP_CMD_DATA;
  assign dat_rd = rd_end && prev_reg.cmd == `NCP_CMD_DATA && fcnt_reg != '0;
  assign opc_w = ncp_opcode_type'(flt_reg.data);
  assign op_go = st_reg == ST_IDLE && ctl_wr;
  assign nw = words_of(opc_reg.fmt);
  assign last_x = xcnt_reg == nw - 3'h1;
  assign push_idx = top_reg - 1'b1;
  assign sidx = TW'(top_reg + opc_w.idx); // RQ21
  assign st_res = store_conv(opc_w.fmt, ncp_ext_type'(stack_reg[sidx]));
  assign ld_fault = op_go && opc_w.op == `NCP_OP_LOAD && valid_reg[push_idx];
  assign st_fault = op_go && opc_w.op == `NCP_OP_STORE && (!valid_reg[sidx] || st_res[80]);
  assign bad_op = op_go && !(opc_w.op inside {`NCP_OP_LOAD, `NCP_OP_STORE, `NCP_OP_ENTER_PROTECTED_INSTRUCTION,
      `NCP_OP_CLEX, `NCP_OP_INIT});
  assign err_set = ld_fault || st_fault || bad_op;
  assign err_clr = op_go && opc_w.op == `NCP_OP_CLEX;
  assign xfer = (st_reg == ST_LOAD && dat_wr) || dat_rd;
  assign in_ready = fcnt_reg != (PW + 1)'(BUF_DEPTH);
  assign push_en = st_reg == ST_STORE && ce_reg && in_ready;
  assign popping = st_reg == ST_DRAIN && dat_rd && last_x && opc_reg.pop;

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      st_reg <= ST_IDLE;
      opc_reg <= '0;
      xcnt_reg <= 3'h0;
      pcnt_reg <= 3'h0;
      outbuf_reg <= 80'h0;
    end else begin
      if (xfer) xcnt_reg <= xcnt_reg + 3'h1;
      if (push_en) pcnt_reg <= pcnt_reg + 3'h1;
      case (st_reg)
        ST_IDLE: if (op_go) begin
          opc_reg <= opc_w;
          xcnt_reg <= 3'h0;
          pcnt_reg <= 3'h0;
          outbuf_reg <= st_res[79:0];
          if (opc_w.op == `NCP_OP_LOAD && !ld_fault) st_reg <= ST_LOAD;
          if (opc_w.op == `NCP_OP_STORE && !st_fault) st_reg <= ST_STORE;
        end
        ST_LOAD: if (dat_wr && last_x) st_reg <= ST_CONV;
        ST_CONV: if (ce_reg) st_reg <= ST_IDLE;
        ST_STORE: if (push_en && pcnt_reg == nw - 3'h1) st_reg <= ST_DRAIN;
        ST_DRAIN: if (dat_rd && last_x) st_reg <= ST_IDLE;
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Operand assembly, lowest word first
  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) opbuf_reg <= 80'h0;
    else if (op_go) opbuf_reg <= 80'h0;
    else if (st_reg == ST_LOAD && dat_wr) opbuf_reg[{xcnt_reg, 4'h0} +: 16] <= flt_reg.data; // RQ18
  end

  generate
    for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stack
      always_ff @(posedge clock_i) begin
        if (st_reg == ST_CONV && ce_reg && push_idx == TW'(g)) begin
          stack_reg[g] <= load_conv(opc_reg.fmt, opbuf_reg); // RQ20 RQ21
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      top_reg <= '0;
      valid_reg <= '0;
    end else if (op_go && opc_w.op == `NCP_OP_INIT) begin
      top_reg <= '0;
      valid_reg <= '0;
    end else if (st_reg == ST_CONV && ce_reg) begin
      top_reg <= push_idx; // RQ21
      valid_reg[push_idx] <= 1'b1;
    end else if (popping) begin
      top_reg <= top_reg + 1'b1;
      valid_reg[top_reg] <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) operand_request_o <= 1'b0;
    else if (op_go && (opc_w.op == `NCP_OP_LOAD && !ld_fault || opc_w.op == `NCP_OP_STORE && !st_fault))
      operand_request_o <= 1'b1; // RQ14
    else if (last_x && (xfer || ack_rise)) operand_request_o <= 1'b0; // RQ24 RQ13
  end

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) error_o <= 1'b0;
    else error_o <= err_set || (error_o && !err_clr); // RQ4
  end

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) protected_mode_o <= 1'b0; // RQ1
    else if (op_go && opc_w.op == `NCP_OP_ENTER_PROTECTED_INSTRUCTION) protected_mode_o <= 1'b1; // RQ2 RQ3
  end

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) busy_o <= 1'b0;
    else busy_o <= st_reg != ST_IDLE; // RQ23
  end

  // Two-entry buffer between store serialiser and host reads
  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      wp_reg <= '0;
      rp_reg <= '0;
      fcnt_reg <= '0;
    end else begin
      if (push_en) wp_reg <= wp_reg + 1'b1;
      if (dat_rd) rp_reg <= rp_reg + 1'b1;
      fcnt_reg <= fcnt_reg + (PW + 1)'(push_en) - (PW + 1)'(dat_rd);
    end
  end

  always_ff @(posedge clock_i) begin
    if (push_en) fmem_reg[wp_reg] <= outbuf_reg[{pcnt_reg, 4'h0} +: 16]; // RQ18
  end

  always_ff @(posedge clock_i or negedge rst_ok_reg) begin
    if (!rst_ok_reg) begin
      data_o <= 16'h0000;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= sel_ok && !flt_reg.rd_n; // RQ22
      if (flt_reg.cmd == `NCP_CMD_DATA) data_o <= fmem_reg[rp_reg];
      else data_o <= {protected_mode_o, error_o, busy_o, operand_request_o, 1'b0, 3'(top_reg),
          8'(valid_reg)};
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_ok_reg);

  sequence s_slow_run;
    ce_reg && !flt_reg.fast ##1 !flt_reg.fast;
  endsequence

  a_real_reset: assert property ($rose(rst_ok_reg) |-> !protected_mode_o) // RQ1
    else $error("not in real mode after reset");
  a_enter_prot: assert property (op_go && opc_w.op == `NCP_OP_ENTER_PROTECTED_INSTRUCTION |=> protected_mode_o) // RQ2
    else $error("enter_protected_instruction did not enter protected mode");
  a_prot_sticky: assert property (protected_mode_o |=> protected_mode_o) // RQ3
    else $error("protected mode left without reset");
  a_error_out: assert property (err_set |=> error_o) // RQ4
    else $error("error not signalled");
  a_div_three: assert property (s_slow_run |=> !ce_reg) // RQ5
    else $error("slow clock enable not one in three");
  a_clock_direct: assert property (flt_reg.fast |=> ce_reg) // RQ6
    else $error("fast mode missed a clock");
  a_lsw_first: assert property (st_reg == ST_LOAD && dat_wr && xcnt_reg == 3'h0 |=> // RQ18
      opbuf_reg[15:0] == $past(flt_reg.data)) else $error("first word not lowest");
  a_select_gate: assert property (data_oe_o |-> $past(sel_ok)) // RQ22
    else $error("driving data while deselected");
  a_busy_exec: assert property (busy_o == $past(st_reg != ST_IDLE)) // RQ23
    else $error("busy does not follow execution");
  a_req_drop: assert property (xfer && last_x |=> !operand_request_o) // RQ24
    else $error("request held after last transfer");
endmodule // ncp_port

// ===== testbench/ncp_host_model.sv
// Host CPU model driving the coprocessor port pins
`timescale 1ns/1ps
module ncp_host_model (
  input wire logic clock_i,
  input wire logic wide_host_i,
  input wire logic [15:0] bus_in_i,
  input wire logic bus_oe_i,
  output logic sel_low_o,
  output logic sel_high_o,
  output logic [1:0] cmd_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ack_o,
  output logic [15:0] bus_out_o
);
  logic ack_reg;
  initial begin
    sel_low_o = 1'b1;
    sel_high_o = 1'b0;
    cmd_o = 2'h0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ack_reg = 1'b0;
    bus_out_o = 16'hA5A5;
  end
  // Wide host ties acknowledge high
  assign ack_o = wide_host_i | ack_reg;
  // One 16-bit cycle to a reserved port, strobe held eight clocks
  task automatic io_cycle(input logic wr, input logic [7:0] port, input logic sel_ok, input logic [15:0] wdata,
      output logic [15:0] rdata);
    @(posedge clock_i);
    // Selects follow the sel_ok argument; the port number only sets the command bits
    sel_low_o <= ~sel_ok;
    sel_high_o <= sel_ok;
    cmd_o <= {port[2], port[1]};
    if (wr) bus_out_o <= wdata;
    repeat (4) @(posedge clock_i);
    if (wr) wr_n_o <= 1'b0;
    else rd_n_o <= 1'b0;
    repeat (8) @(posedge clock_i);
    // Other drivers off; an undriven bus reads as inverted leftover
    rdata = bus_oe_i ? bus_in_i : ~bus_out_o;
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (8) @(posedge clock_i);
    sel_low_o <= 1'b1;
    sel_high_o <= 1'b0;
    bus_out_o <= ~bus_out_o;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic pulse_ack();
    @(posedge clock_i);
    ack_reg <= 1'b1;
    repeat (8) @(posedge clock_i);
    ack_reg <= 1'b0;
  endtask
endmodule // ncp_host_model

// ===== testbench/ncp_port_tb_top.sv
// Self-checking testbench of the coprocessor host port
`timescale 1ns/1ps
module ncp_port_tb_top;
  logic clock_i, nrst_i, clock_mode_select_i, wide_host;
  logic sel_low, sel_high, rd_n, wr_n, ack, data_oe, busy, error, request, prot;
  logic [1:0] cmd;
  logic [15:0] wdata, rdata, v;
  int n_mismatch, num_checks;

  ncp_port dut (.clock_i(clock_i), .nrst_i(nrst_i), .clock_mode_select_i(clock_mode_select_i),
    .select_active_low_i(sel_low), .select_active_high_i(sel_high), .command_bit_zero_i(cmd[0]),
    .command_bit_one_i(cmd[1]), .coproc_read_strobe_n_i(rd_n), .coproc_write_strobe_n_i(wr_n),
    .operand_acknowledge_i(ack), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe), .busy_o(busy),
    .error_o(error), .operand_request_o(request), .protected_mode_o(prot));
  ncp_host_model host (.clock_i(clock_i), .wide_host_i(wide_host), .bus_in_i(rdata), .bus_oe_i(data_oe),
    .sel_low_o(sel_low), .sel_high_o(sel_high), .cmd_o(cmd), .rd_n_o(rd_n), .wr_n_o(wr_n), .ack_o(ack),
    .bus_out_o(wdata));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_flag(input int which, input logic val);
    for (int i = 0; i < 80; i++) begin
      if ((which == 0 ? busy : which == 1 ? request : error) === val) break;
      @(posedge clock_i);
    end
  endtask
  task automatic wr(input logic [7:0] port, input logic [15:0] d);
    host.io_cycle(1'b1, port, 1'b1, d, v);
  endtask
  task automatic rd(input logic [7:0] port);
    host.io_cycle(1'b0, port, 1'b1, 16'h0000, v);
  endtask
  task automatic op(input logic [15:0] code);
    wr(8'hF8, code);
    wait_flag(0, 1'b0);
  endtask
  task automatic load(input logic [15:0] code, input logic [79:0] val, input int n);
    wr(8'hF8, code);
    wait_flag(1, 1'b1);
    check("busy", {15'h0000, busy}, 16'h0001);
    for (int k = 0; k < n; k++) wr(8'hFC, val[16*k +: 16]);
    wait_flag(1, 1'b0);
    check("request", {15'h0000, request}, 16'h0000);
    wait_flag(0, 1'b0);
  endtask
  task automatic store(input logic [15:0] code, input logic [79:0] exp, input int n);
    wr(8'hF8, code);
    wait_flag(1, 1'b1);
    for (int k = 0; k < n; k++) begin
      rd(8'hFC);
      check("operand word", v, exp[16*k +: 16]);
    end
    wait_flag(0, 1'b0);
    check("busy", {15'h0000, busy}, 16'h0000);
    check("request", {15'h0000, request}, 16'h0000);
  endtask
  task automatic check_error(input logic exp);
    wait_flag(2, exp);
    check("error", {15'h0000, error}, {15'h0000, exp});
  endtask

  initial begin
    nrst_i = 1'b0;
    clock_mode_select_i = 1'b1;
    wide_host = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    check("protected", {15'h0000, prot}, 16'h0000);
    rd(8'hF8);
    check("status flags", {12'h000, v[15:12]}, 16'h0000);
    // Integer and extended round trips, then reals of one via bias change
    load(16'h0001, 80'h1234, 1);
    store(16'h0002, 80'h1234, 1);
    load(16'h0061, 80'h3FFF_C001_0002_0003_0004, 5);
    store(16'h0462, 80'h3FFF_C001_0002_0003_0004, 5);
    load(16'h0041, 80'h3F80_0000, 2);
    store(16'h0462, 80'h3FFF_8000_0000_0000_0000, 5);
    load(16'h0051, 80'h3FF0_0000_0000_0000, 4);
    store(16'h0462, 80'h3FFF_8000_0000_0000_0000, 5);
    // Fill all eight entries, reach the deepest one by index
    for (int i = 0; i < 7; i++) load(16'h0001, 80'(i), 1);
    store(16'h0382, 80'h1234, 1);
    op(16'h0001);
    check_error(1'b1);
    rd(8'hF8);
    check("status error", {15'h0000, v[14]}, 16'h0001);
    op(16'h0004);
    check_error(1'b0);
    op(16'h0005);
    op(16'h0002);
    check_error(1'b1);
    op(16'h000F);
    op(16'h0004);
    check_error(1'b0);
    // Acknowledge withdraws the request before the word moves
    wide_host <= 1'b0;
    wr(8'hF8, 16'h0001);
    wait_flag(1, 1'b1);
    host.pulse_ack();
    wait_flag(1, 1'b0);
    check("request after ack", {15'h0000, request}, 16'h0000);
    wr(8'hFC, 16'h0055);
    wait_flag(0, 1'b0);
    wide_host <= 1'b1;
    // Divided internal clock still completes a transfer
    clock_mode_select_i <= 1'b0;
    store(16'h0002, 80'h0055, 1);
    clock_mode_select_i <= 1'b1;
    store(16'h0402, 80'h0055, 1);
    // Packed decimal 1234 comes back as a word integer
    load(16'h0031, 80'h1234, 5);
    store(16'h0402, 80'h04D2, 1);
    // Deselected opcode must not act
    host.io_cycle(1'b1, 8'hF8, 1'b0, 16'h0003, v);
    repeat (10) @(posedge clock_i);
    check("protected", {15'h0000, prot}, 16'h0000);
    op(16'h0003);
    check("protected", {15'h0000, prot}, 16'h0001);
    op(16'h0005);
    op(16'h0004);
    check("protected", {15'h0000, prot}, 16'h0001);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    check("protected", {15'h0000, prot}, 16'h0000);
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    print_verdict();
  end
endmodule // ncp_port_tb_top
